// ---- inc/rms_pkg.sv ----
// Shared constants and types for the receiver mode and status pin block.
package rms_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 200_000_000;
	localparam int CYC_PER_MS    = CLK_HZ / 1000;
	localparam int PULSE_MS      = 83;
	localparam int PULSE_CYC     = CYC_PER_MS * PULSE_MS;
	localparam int SEC_CYC       = CLK_HZ;
	localparam int BLINK_MS      = 500;
	localparam int BLINK_CYC     = CYC_PER_MS * BLINK_MS;
	localparam int BAUD_HI       = 9600;
	localparam int BAUD_LO       = 4800;
	localparam logic [15:0] DIV_HI  = 16'(CLK_HZ / BAUD_HI);
	localparam logic [15:0] DIV_LO  = 16'(CLK_HZ / BAUD_LO);
	localparam logic [15:0] DIV_MIN = 16'h0010;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_POWER    = 5'h00;
	localparam logic [4:0] REG_PORTCFG  = 5'h04;
	localparam logic [4:0] REG_PULSE    = 5'h08;
	localparam logic [4:0] REG_STATUS   = 5'h0C;
	localparam logic [4:0] REG_IRQ_STAT = 5'h10;
	localparam logic [4:0] REG_IRQ_MASK = 5'h14;
	localparam logic [4:0] REG_TXDATA   = 5'h18;
	localparam logic [4:0] REG_RXDATA   = 5'h1C;
	localparam int PWR_ON_BIT   = 0;
	localparam int PORT_OVR_BIT = 16;
	localparam int PULSE_EN_BIT = 0;
	localparam int IVL_LSB      = 8;
	localparam int IVL_W        = 6;
	localparam logic [IVL_W-1:0] IVL_MIN = 6'h01;
	localparam logic [IVL_W-1:0] IVL_MAX = 6'h3C;
	localparam int IRQ_ENGINE = 0;
	localparam int IRQ_RX     = 1;
	localparam int IRQ_TX     = 2;
	localparam int IRQ_PULSE  = 3;
	localparam int IRQ_W      = 4;
	// Synchroniser order: rx, standby_n, manual_reset_n, baud, engine.
	localparam logic [4:0] SYNC_RST = 5'h1C;

	typedef enum logic [1:0] {
		RMS_ACTIVE  = 2'b00,
		RMS_PSAVE   = 2'b01,
		RMS_STANDBY = 2'b10
	} rms_mode_type;

	typedef struct packed {
		logic         tx_busy;
		logic         rx_full;
		logic         almanac;
		logic         engine;
		rms_mode_type mode;
	} rms_status_type;
endpackage : rms_pkg

// ---- sim/rms_host_model.sv ----
// Host-side serial partner: sends and receives 8N1 frames.
`timescale 1ns/1ps
module rms_host_model (
	input  wire logic ref_clk,       // System clock
	input  wire logic nav_serial_tx, // Line from the block
	output logic      nav_serial_rx  // Line to the block, idle high
);
	initial nav_serial_rx = 1'b1;

	// Start bit, eight data bits LSB first, one stop bit, no parity.
	task automatic send_byte(input logic [7:0] b, input int div);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			nav_serial_rx <= f[i];
			repeat (div) @(posedge ref_clk);
		end
	endtask : send_byte

	// Samples mid-bit so a slightly early or late edge still reads right.
	task automatic get_byte(input int div, output logic [7:0] b);
		int n;
		for (n = 0; n < 40 * div && nav_serial_tx !== 1'b0; n++) @(posedge ref_clk);
		repeat (div + div / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			b[i] = nav_serial_tx;
			repeat (div) @(posedge ref_clk);
		end
	endtask : get_byte
endmodule : rms_host_model

// ---- sim/rms_top_test.sv ----
// Self-checking bench for the receiver mode and status pin block.
`timescale 1ns/1ps
module rms_top_test;
	import rms_pkg::*;
	localparam int SEC = 1000;
	localparam int PW  = 100;
	localparam int BL  = 20;
	localparam int DIV = 16;
	logic         ref_clk, nrst, engine_request, baud_select, manual_reset_n;
	logic         standby_request_n, nav_serial_rx, almanac_ok, fix_present, tracking;
	logic [4:0]   avs_address;
	logic         avs_read, avs_write, avs_waitrequest, nav_serial_tx, timing_pulse_out;
	logic [31:0]  avs_writedata, avs_readdata, rd;
	logic         almanac_valid, fix_status_indicator, engine_on, mcu_clk_run, rtc_run, irq;
	logic [7:0]   b;
	rms_mode_type op_mode;
	int           fail_count = 0;
	int           checked = 0;
	int           cyc = 0;
	int           n, w;

	rms_top #(.SEC_CYC_P(SEC), .PULSE_CYC_P(PW), .BLINK_CYC_P(BL)) u_rms_top (
		.ref_clk(ref_clk), .nrst(nrst), .engine_request(engine_request),
		.baud_select(baud_select), .manual_reset_n(manual_reset_n),
		.standby_request_n(standby_request_n), .nav_serial_rx(nav_serial_rx),
		.almanac_ok(almanac_ok), .fix_present(fix_present), .tracking(tracking),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .nav_serial_tx(nav_serial_tx),
		.timing_pulse_out(timing_pulse_out), .almanac_valid(almanac_valid),
		.fix_status_indicator(fix_status_indicator), .engine_on(engine_on),
		.mcu_clk_run(mcu_clk_run), .rtc_run(rtc_run), .op_mode(op_mode), .irq(irq));
	rms_host_model u_rms_host_model (.ref_clk(ref_clk), .nav_serial_tx(nav_serial_tx),
		.nav_serial_rx(nav_serial_rx));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// A hang is counted as a mismatch and closes the run.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic wt(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : wt

	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t: %s", $time, m);
		end
	endtask : chk

	// Holds the request until waitrequest is sampled low, then releases it.
	task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
		int k;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk(k < 50, "bus stalled");
		@(posedge ref_clk);
	endtask : bus

	task automatic end_of_test();
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		wt(8);
		chk(engine_on === 1'b0 && op_mode === RMS_PSAVE, "engine ran from low pin");
		chk(mcu_clk_run === 1'b1 && rtc_run === 1'b1, "clocks stopped");
		bus(0, REG_PULSE, 0);
		chk(rd[PULSE_EN_BIT] === 1'b0 && timing_pulse_out === 1'b0, "pulse on");
		bus(0, REG_STATUS, 0);
		chk(rd === 32'(RMS_PSAVE), "status after reset wrong");
		bus(0, 5'h1E, 0);
		chk(rd === 32'h0000_0000, "unmapped read not zero");
	endtask : t_reset

	task automatic t_engine();
		engine_request <= 1'b1;
		wt(1);
		chk(engine_on === 1'b0, "pin used unsynchronised");
		wt(8);
		chk(engine_on === 1'b1 && op_mode === RMS_ACTIVE, "engine not started");
		bus(1, REG_POWER, 32'h0000_0000);
		wt(3);
		chk(engine_on === 1'b1, "command overrode high pin");
		engine_request <= 1'b0;
		wt(8);
		chk(engine_on === 1'b0 && op_mode === RMS_PSAVE, "engine not stopped");
		bus(1, REG_POWER, 32'h0000_0001);
		wt(3);
		chk(engine_on === 1'b1, "power command ignored");
		bus(1, REG_POWER, 32'h0000_0000);
		wt(3);
		chk(engine_on === 1'b0, "power off command ignored");
	endtask : t_engine

	task automatic t_standby();
		engine_request <= 1'b1;
		standby_request_n <= 1'b0;
		wt(8);
		chk(op_mode === RMS_STANDBY && engine_on === 1'b0, "no standby");
		chk(mcu_clk_run === 1'b0 && rtc_run === 1'b1, "standby clocks wrong");
		standby_request_n <= 1'b1;
		wt(8);
		chk(op_mode === RMS_ACTIVE && mcu_clk_run === 1'b1, "standby not left");
	endtask : t_standby

	task automatic t_status();
		almanac_ok <= 1'b1;
		wt(4);
		chk(almanac_valid === 1'b1, "almanac valid not shown");
		almanac_ok <= 1'b0;
		tracking <= 1'b1;
		wt(4);
		chk(almanac_valid === 1'b0, "stale almanac shown valid");
		for (n = 0; n < 99 && fix_status_indicator !== 1'b1; n++) @(posedge ref_clk);
		for (n = 0; n < 99 && fix_status_indicator === 1'b1; n++) @(posedge ref_clk);
		for (w = 0; w < 99 && fix_status_indicator !== 1'b1; w++) @(posedge ref_clk);
		for (n = 0; n < 99 && fix_status_indicator === 1'b1; n++) @(posedge ref_clk);
		chk(n == BL && w == BL, "blink phases wrong");
		fix_present <= 1'b1;
		wt(4);
		chk(fix_status_indicator === 1'b0, "indicator not low on fix");
		wt(BL + 4);
		chk(fix_status_indicator === 1'b0, "indicator blinks with fix");
	endtask : t_status

	task automatic t_uart();
		baud_select <= 1'b1;
		wt(4);
		bus(0, REG_PORTCFG, 0);
		chk(rd[15:0] === DIV_HI, "high baud divisor wrong");
		baud_select <= 1'b0;
		wt(4);
		bus(0, REG_PORTCFG, 0);
		chk(rd[15:0] === DIV_LO, "low baud divisor wrong");
		bus(1, REG_PORTCFG, 32'h0001_0010);
		bus(0, REG_PORTCFG, 0);
		chk(rd[15:0] === 16'h0010, "override not applied");
		bus(1, REG_IRQ_MASK, 32'h0000_0002);
		bus(1, REG_IRQ_STAT, 32'h0000_000F);
		u_rms_host_model.send_byte(8'hA5, DIV);
		wt(DIV);
		chk(irq === 1'b1, "rx interrupt missing");
		bus(1, REG_IRQ_MASK, 32'h0000_0000);
		chk(irq === 1'b0, "masked interrupt raised");
		bus(0, REG_RXDATA, 0);
		chk(rd[7:0] === 8'hA5, "rx byte wrong");
		bus(1, REG_IRQ_MASK, 32'h0000_0002);
		chk(irq === 1'b1, "unmasked interrupt lost");
		bus(1, REG_IRQ_STAT, 32'h0000_0002);
		wt(1);
		chk(irq === 1'b0, "interrupt not cleared");
		fork
			u_rms_host_model.get_byte(DIV, b);
			bus(1, REG_TXDATA, 32'h0000_003C);
		join
		chk(b === 8'h3C, "tx byte wrong");
	endtask : t_uart

	task automatic t_pulse();
		bus(1, REG_PULSE, 32'h0000_3F01);
		bus(0, REG_PULSE, 0);
		chk(rd[13:8] === IVL_MAX, "interval not clamped high");
		bus(1, REG_PULSE, 32'h0000_0001);
		bus(0, REG_PULSE, 0);
		chk(rd[13:8] === IVL_MIN, "interval not clamped low");
		for (n = 0; n < SEC + 50 && timing_pulse_out !== 1'b1; n++) @(posedge ref_clk);
		chk(n > SEC - 20 && n < SEC + 20, "first pulse late");
		for (w = 0; w < 300 && timing_pulse_out === 1'b1; w++) @(posedge ref_clk);
		chk(w == PW, "pulse width wrong");
		for (n = 0; n < SEC && timing_pulse_out !== 1'b1; n++) @(posedge ref_clk);
		chk(n == SEC - PW, "pulse period wrong");
	endtask : t_pulse

	task automatic t_manual();
		manual_reset_n <= 1'b0;
		wt(6);
		manual_reset_n <= 1'b1;
		wt(6);
		chk(engine_on === 1'b1, "engine not restarted");
		bus(0, REG_PULSE, 0);
		chk(rd[PULSE_EN_BIT] === 1'b0, "pulse kept over reset");
		bus(0, REG_PORTCFG, 0);
		chk(rd[15:0] === DIV_LO, "override kept over reset");
		manual_reset_n <= 1'b0;
		wt(3);
		engine_request <= 1'b0;
		wt(6);
		manual_reset_n <= 1'b1;
		wt(6);
		chk(engine_on === 1'b0, "engine started from low pin");
	endtask : t_manual

	initial begin
		nrst = 1'b0;
		{engine_request, baud_select, almanac_ok, fix_present, tracking} = 5'h00;
		{manual_reset_n, standby_request_n} = 2'b11;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		wt(16);
		nrst <= 1'b1;
		t_reset();
		t_engine();
		t_standby();
		t_status();
		t_uart();
		t_pulse();
		t_manual();
		end_of_test();
	end
endmodule : rms_top_test

// ---- src/rms_top.sv ----
// Engine on/off, operating mode, reset, serial port and status pin logic.
`timescale 1ns/1ps

// How it works
// RQ1 - Pin high at reset or rising starts engine.
// RQ2 - Pin low at reset keeps engine stopped.
// RQ3 - Pin falling while running stops engine.
// RQ4 - With pin low, power command sets engine.
// RQ5 - Baud pin: high 9600, low 4800, 8N1.
// RQ6 - Port command replaces pin-selected baud rate.
// RQ7 - Serial port is an async receiver/transmitter pair.
// RQ8 - Each timing pulse lasts 83 ms.
// RQ9 - Pulse off after reset; only command enables.
// RQ10 - Reset from power-on or manual reset low.
// RQ11 - Almanac output high only active and valid.
// RQ12 - Indicator low on fix, blinks while tracking.
// RQ13 - Standby input low selects stand-by mode.
// RQ14 - Active mode runs engine with both pins high.
// RQ15 - Power-save: engine off, MCU clock runs.
// RQ16 - Stand-by stops engine and MCU clock, RTC runs.
// RQ17 - Pulse interval from one to sixty seconds.
// RQ18 - Control pins synchronised before use.
// RQ19 - Blink phases equal, fixed parameterised length.
module rms_top #(
	parameter int SEC_CYC_P   = rms_pkg::SEC_CYC,   // Cycles per second tick
	parameter int PULSE_CYC_P = rms_pkg::PULSE_CYC, // Timing pulse width in cycles
	parameter int BLINK_CYC_P = rms_pkg::BLINK_CYC  // Indicator half period in cycles
) (
	input  wire logic                  ref_clk,              // System clock
	input  wire logic                  nrst,                 // Power-on reset, active low
	input  wire logic                  engine_request,       // Engine on/off pin
	input  wire logic                  baud_select,          // Baud select pin
	input  wire logic                  manual_reset_n,       // Manual reset pin, active low
	input  wire logic                  standby_request_n,    // Stand-by request pin
	input  wire logic                  nav_serial_rx,        // Serial receive line
	input  wire logic                  almanac_ok,           // Almanac tests valid and current
	input  wire logic                  fix_present,          // Position fix exists
	input  wire logic                  tracking,             // Satellites tracked
	input  wire logic [4:0]            avs_address,          // Register byte address
	input  wire logic                  avs_read,             // Read request
	input  wire logic                  avs_write,            // Write request
	input  wire logic [31:0]           avs_writedata,        // Write data
	output logic      [31:0]           avs_readdata,         // Read data
	output logic                       avs_waitrequest,      // Stall
	output logic                       nav_serial_tx,        // Serial transmit line
	output logic                       timing_pulse_out,     // Timing pulse
	output logic                       almanac_valid,        // Almanac status
	output logic                       fix_status_indicator, // Fix/tracking indicator
	output logic                       engine_on,            // Engine running
	output logic                       mcu_clk_run,          // MCU clock enabled
	output logic                       rtc_run,              // RTC running
	output rms_pkg::rms_mode_type      op_mode,              // Operating mode
	output logic                       irq                   // Interrupt, active high
);
	import rms_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers and reset condition
	// ----------------------------------------------------------------
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic       req_s;
	logic       baud_s;
	logic       mrst_s;
	logic       stby_s;
	logic       rx_s;
	logic       boot_q;
	logic       in_reset;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
		end else begin
			sync1_q <= {nav_serial_rx, standby_request_n, manual_reset_n,
				baud_select, engine_request}; // RQ18
			sync2_q <= sync1_q; // RQ18
		end
	end

	assign {rx_s, stby_s, mrst_s, baud_s, req_s} = sync2_q;

	// The first cycle after power-on release stands in for the pin capture,
	// since an asynchronous reset may only load constants.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			boot_q <= 1'b0;
		end else begin
			boot_q <= 1'b1;
		end
	end

	assign in_reset = !boot_q || !mrst_s; // RQ10

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic wr_go;
	logic rd_go;

	assign wr_go = avs_write && !avs_waitrequest;
	assign rd_go = avs_read && !avs_waitrequest;

	// One wait cycle per access: read data is loaded while waitrequest drops.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// ----------------------------------------------------------------
	// Engine on/off
	// ----------------------------------------------------------------
	logic engine_q;
	logic req_prev_q;
	logic engine_prev_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			engine_q      <= 1'b0;
			req_prev_q    <= 1'b0;
			engine_prev_q <= 1'b0;
		end else begin
			req_prev_q    <= req_s;
			engine_prev_q <= engine_q;
			if (in_reset) begin
				engine_q <= req_s; // RQ1 RQ2
			end else if (req_s && !req_prev_q) begin
				engine_q <= 1'b1; // RQ1
			end else if (!req_s && req_prev_q) begin
				engine_q <= 1'b0; // RQ3
			end else if (!req_s && wr_go && avs_address == REG_POWER) begin
				engine_q <= avs_writedata[PWR_ON_BIT]; // RQ4
			end
		end
	end

	// ----------------------------------------------------------------
	// Operating mode
	// ----------------------------------------------------------------
	rms_mode_type mode_d;
	logic         eng_run_d;
	logic         mcu_run_d;

	always_comb begin
		if (!stby_s) begin
			mode_d = RMS_STANDBY; // RQ13
		end else if (engine_q) begin
			mode_d = RMS_ACTIVE; // RQ14
		end else begin
			mode_d = RMS_PSAVE; // RQ15
		end
	end

	always_comb begin
		eng_run_d = 1'b0;
		mcu_run_d = 1'b0;
		unique case (mode_d)
			RMS_ACTIVE: begin
				eng_run_d = 1'b1; // RQ14
				mcu_run_d = 1'b1;
			end
			RMS_PSAVE: begin
				mcu_run_d = 1'b1; // RQ15
			end
			RMS_STANDBY: begin
				eng_run_d = 1'b0; // RQ16
			end
			default: begin
				eng_run_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			op_mode       <= RMS_PSAVE;
			engine_on     <= 1'b0;
			mcu_clk_run   <= 1'b1;
			rtc_run       <= 1'b1;
			almanac_valid <= 1'b0;
		end else begin
			op_mode       <= mode_d;
			engine_on     <= eng_run_d;
			mcu_clk_run   <= mcu_run_d;
			rtc_run       <= 1'b1; // RQ16
			almanac_valid <= !in_reset && mode_d == RMS_ACTIVE && almanac_ok; // RQ11
		end
	end

	// ----------------------------------------------------------------
	// Fix status indicator
	// ----------------------------------------------------------------
	logic [31:0] blink_cnt_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			blink_cnt_q          <= 32'h0000_0000;
			fix_status_indicator <= 1'b0;
		end else if (fix_present || !tracking) begin
			blink_cnt_q          <= 32'h0000_0000;
			fix_status_indicator <= 1'b0; // RQ12
		end else if (blink_cnt_q == 32'(BLINK_CYC_P - 1)) begin
			blink_cnt_q          <= 32'h0000_0000;
			fix_status_indicator <= !fix_status_indicator; // RQ12 RQ19
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Port and pulse configuration
	// ----------------------------------------------------------------
	logic             port_ovr_q;
	logic [15:0]      port_div_q;
	logic             pulse_en_q;
	logic [IVL_W-1:0] pulse_ivl_q;
	logic [IVL_W-1:0] ivl_wr;
	logic [15:0]      div;

	assign ivl_wr = avs_writedata[IVL_LSB +: IVL_W];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			port_ovr_q  <= 1'b0;
			port_div_q  <= DIV_LO;
			pulse_en_q  <= 1'b0;
			pulse_ivl_q <= IVL_MIN;
		end else if (in_reset) begin
			port_ovr_q  <= 1'b0;
			port_div_q  <= DIV_LO;
			pulse_en_q  <= 1'b0; // RQ9
			pulse_ivl_q <= IVL_MIN;
		end else if (wr_go && avs_address == REG_PORTCFG) begin
			port_ovr_q <= avs_writedata[PORT_OVR_BIT]; // RQ6
			port_div_q <= (avs_writedata[15:0] < DIV_MIN) ? DIV_MIN : avs_writedata[15:0];
		end else if (wr_go && avs_address == REG_PULSE) begin
			pulse_en_q <= avs_writedata[PULSE_EN_BIT]; // RQ9
			if (ivl_wr < IVL_MIN) begin
				pulse_ivl_q <= IVL_MIN; // RQ17
			end else if (ivl_wr > IVL_MAX) begin
				pulse_ivl_q <= IVL_MAX; // RQ17
			end else begin
				pulse_ivl_q <= ivl_wr;
			end
		end
	end

	assign div = port_ovr_q ? port_div_q : (baud_s ? DIV_HI : DIV_LO); // RQ5 RQ6

	// ----------------------------------------------------------------
	// Timing pulse
	// ----------------------------------------------------------------
	logic [31:0]      sec_cnt_q;
	logic [IVL_W-1:0] ivl_cnt_q;
	logic [31:0]      pw_cnt_q;
	logic             pulse_start;

	assign pulse_start = pulse_en_q && sec_cnt_q == 32'(SEC_CYC_P - 1)
		&& ivl_cnt_q == pulse_ivl_q - IVL_MIN;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sec_cnt_q <= 32'h0000_0000;
			ivl_cnt_q <= '0;
		end else if (!pulse_en_q) begin
			sec_cnt_q <= 32'h0000_0000;
			ivl_cnt_q <= '0;
		end else if (sec_cnt_q == 32'(SEC_CYC_P - 1)) begin
			sec_cnt_q <= 32'h0000_0000;
			ivl_cnt_q <= pulse_start ? '0 : ivl_cnt_q + IVL_MIN; // RQ17
		end else begin
			sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timing_pulse_out <= 1'b0;
			pw_cnt_q         <= 32'h0000_0000;
		end else if (!pulse_en_q) begin
			timing_pulse_out <= 1'b0; // RQ9
			pw_cnt_q         <= 32'h0000_0000;
		end else if (pulse_start) begin
			timing_pulse_out <= 1'b1;
			pw_cnt_q         <= 32'(PULSE_CYC_P - 1); // RQ8
		end else if (timing_pulse_out) begin
			if (pw_cnt_q == 32'h0000_0000) begin
				timing_pulse_out <= 1'b0; // RQ8
			end else begin
				pw_cnt_q <= pw_cnt_q - 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Serial transmitter and receiver, 8 data bits, no parity, 1 stop
	// ----------------------------------------------------------------
	logic        tx_busy_q;
	logic [8:0]  tx_shift_q;
	logic [3:0]  tx_bit_q;
	logic [15:0] tx_cnt_q;
	logic        tx_done;
	logic        rx_busy_q;
	logic [7:0]  rx_shift_q;
	logic [3:0]  rx_bit_q;
	logic [15:0] rx_cnt_q;
	logic [7:0]  rx_data_q;
	logic        rx_full_q;
	logic        rx_done;

	assign tx_done = tx_busy_q && tx_cnt_q == 16'h0000 && tx_bit_q == 4'h9;
	assign rx_done = rx_busy_q && rx_cnt_q == 16'h0000 && rx_bit_q == 4'h9 && rx_s;

	// A write while a byte is still shifting out is dropped; poll tx_busy.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_busy_q     <= 1'b0;
			tx_shift_q    <= 9'h1FF;
			tx_bit_q      <= 4'h0;
			tx_cnt_q      <= 16'h0000;
			nav_serial_tx <= 1'b1;
		end else if (!tx_busy_q) begin
			if (wr_go && avs_address == REG_TXDATA) begin
				tx_busy_q     <= 1'b1; // RQ7
				tx_shift_q    <= {1'b1, avs_writedata[7:0]};
				tx_bit_q      <= 4'h0;
				tx_cnt_q      <= div - 16'h0001;
				nav_serial_tx <= 1'b0;
			end
		end else if (tx_cnt_q != 16'h0000) begin
			tx_cnt_q <= tx_cnt_q - 16'h0001;
		end else if (tx_bit_q == 4'h9) begin
			tx_busy_q <= 1'b0;
		end else begin
			nav_serial_tx <= tx_shift_q[0]; // RQ5
			tx_shift_q    <= {1'b1, tx_shift_q[8:1]};
			tx_bit_q      <= tx_bit_q + 4'h1;
			tx_cnt_q      <= div - 16'h0001;
		end
	end

	// Sampling at mid-bit from the start edge; a bad stop bit drops the byte.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_busy_q  <= 1'b0;
			rx_shift_q <= 8'h00;
			rx_bit_q   <= 4'h0;
			rx_cnt_q   <= 16'h0000;
		end else if (!rx_busy_q) begin
			if (!rx_s) begin
				rx_busy_q <= 1'b1; // RQ7
				rx_bit_q  <= 4'h0;
				rx_cnt_q  <= {1'b0, div[15:1]};
			end
		end else if (rx_cnt_q != 16'h0000) begin
			rx_cnt_q <= rx_cnt_q - 16'h0001;
		end else begin
			rx_cnt_q <= div - 16'h0001;
			if (rx_bit_q == 4'h0 && rx_s) begin
				rx_busy_q <= 1'b0;
			end else if (rx_bit_q == 4'h9) begin
				rx_busy_q <= 1'b0;
			end else begin
				if (rx_bit_q != 4'h0) begin
					rx_shift_q <= {rx_s, rx_shift_q[7:1]};
				end
				rx_bit_q <= rx_bit_q + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_data_q <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (rx_done) begin
			rx_data_q <= rx_shift_q;
			rx_full_q <= 1'b1;
		end else if (rd_go && avs_address == REG_RXDATA) begin
			rx_full_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and read data
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_d;
	rms_status_type   status;

	always_comb begin
		irq_set             = '0;
		irq_set[IRQ_ENGINE] = engine_q != engine_prev_q;
		irq_set[IRQ_RX]     = rx_done;
		irq_set[IRQ_TX]     = tx_done;
		irq_set[IRQ_PULSE]  = pulse_start;
		irq_clr             = (wr_go && avs_address == REG_IRQ_STAT) ?
			avs_writedata[IRQ_W-1:0] : '0;
		irq_stat_d          = (irq_stat_q & ~irq_clr) | irq_set;
		irq_mask_d          = (wr_go && avs_address == REG_IRQ_MASK) ?
			avs_writedata[IRQ_W-1:0] : irq_mask_q;
	end

	// The line uses the next mask as well as the next status, so that a mask
	// write reaches irq in the same cycle as a status change does.

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq        <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq        <= |(irq_stat_d & irq_mask_d);
		end
	end

	assign status = '{tx_busy: tx_busy_q, rx_full: rx_full_q, almanac: almanac_valid,
		engine: engine_q, mode: mode_d};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				REG_POWER:    avs_readdata <= 32'(engine_q);
				REG_PORTCFG:  avs_readdata <= {15'h0000, port_ovr_q, div};
				REG_PULSE:    avs_readdata <= {18'h0_0000, pulse_ivl_q, 7'h00, pulse_en_q};
				REG_STATUS:   avs_readdata <= 32'(status);
				REG_IRQ_STAT: avs_readdata <= 32'(irq_stat_q);
				REG_IRQ_MASK: avs_readdata <= 32'(irq_mask_q);
				REG_TXDATA:   avs_readdata <= 32'(tx_busy_q);
				REG_RXDATA:   avs_readdata <= 32'(rx_data_q);
				default:      avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [31:0] plen_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			plen_q <= 32'h0000_0000;
		end else begin
			plen_q <= timing_pulse_out ? plen_q + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_engine_rise;
		!in_reset && req_s && !req_prev_q |=> engine_q;
	endproperty
	a_engine_rise: assert property (p_engine_rise) else $error("engine not started"); // RQ1

	property p_reset_low;
		in_reset && !req_s |=> !engine_q;
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("engine ran after reset"); // RQ2

	property p_engine_fall;
		!in_reset && !req_s && req_prev_q |=> !engine_q ##1 !engine_on;
	endproperty
	a_engine_fall: assert property (p_engine_fall) else $error("engine not stopped"); // RQ3

	property p_standby;
		!stby_s |=> op_mode == RMS_STANDBY && !mcu_clk_run && !engine_on && rtc_run;
	endproperty
	a_standby: assert property (p_standby) else $error("stand-by not entered"); // RQ13 RQ16

	property p_psave;
		stby_s && !engine_q |=> op_mode == RMS_PSAVE && mcu_clk_run && !engine_on;
	endproperty
	a_psave: assert property (p_psave) else $error("power-save wrong"); // RQ15

	property p_pulse_width;
		$fell(timing_pulse_out) && pulse_en_q |-> $past(plen_q) == 32'(PULSE_CYC_P - 1);
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong"); // RQ8

	property p_pulse_reset;
		in_reset |=> !pulse_en_q ##1 !timing_pulse_out;
	endproperty
	a_pulse_reset: assert property (p_pulse_reset) else $error("pulse on after reset"); // RQ9

	property p_almanac;
		mode_d != RMS_ACTIVE || !almanac_ok |=> !almanac_valid;
	endproperty
	a_almanac: assert property (p_almanac) else $error("almanac high wrongly"); // RQ11

	property p_fix_low;
		fix_present |=> !fix_status_indicator;
	endproperty
	a_fix_low: assert property (p_fix_low) else $error("indicator not low on fix"); // RQ12

	property p_waitreq;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_waitreq: assert property (p_waitreq) else $error("bus answer timing wrong");
endmodule : rms_top
